/* verilog/cartridge_transfer_control.sv */
// Operation
// - two four-switch groups on the cartridge are sampled at power-up
// - auto_load_select on copies cartridge data into the terminal
// - auto_backup_select on copies terminal data into the cartridge
// - manual_select on takes direction and bank from operator inputs
// - content_type off means screen data, on means system program
// - terminal_write_enable off forbids writes into the terminal
// - cartridge_write_enable off forbids writes into the cartridge
// - bank_select picks bank 0 or bank 1 for automatic transfers
// - combined_transfer moves program and screen in automatic modes only, ignoring type and bank
// - mode error unless exactly one mode switch is on
// - protect error when destination write enable forbids writing
// - data error when content kind mismatches the terminal area
// - combined backup: program to bank 0, screen to bank 1
// - combined load needs exactly one bank holding a program
// - writing one bank replaces it and leaves the other untouched
// - automatic transfer starts at power-up without operator action
// - phases preparing, transmitting, verifying, finished; bytes and blocks counted
// - lamp blinks 1 s preparing, 0.5 s transmit/verify, steady finished
// - system program loads only when target model matches
// - on error the buzzer sounds continuously and the lamp blinks
// - lamp stays off during a manual transfer
`timescale 1ns/100ps
module cartridge_transfer_control
(
    input  wire logic                                         clock_in,
    input  wire logic                                         reset_n_in,
    input  wire logic [3:0]                                   switch_group1_in,
    input  wire logic [3:0]                                   switch_group2_in,
    input  wire logic                                         manual_start_in,
    input  wire logic                                         manual_to_cartridge_in,
    input  wire logic                                         manual_bank_in,
    input  wire logic                                         manual_ack_in,
    input  wire logic                                         bank0_is_program_in,
    input  wire logic                                         bank1_is_program_in,
    input  wire logic                                         model_match_in,
    input  wire logic [7:0]                                   src_data_in,
    input  wire logic                                         src_valid_in,
    output logic                                              src_ready_out,
    output logic [7:0]                                        dst_data_out,
    output logic                                              dst_valid_out,
    input  wire logic                                         dst_ready_in,
    output logic                                              dst_is_cartridge_out,
    output logic                                              dst_bank_out,
    output logic                                              dst_is_program_out,
    output logic                                              verify_req_out,
    input  wire logic                                         verify_done_in,
    input  wire logic                                         verify_ok_in,
    output cartridge_transfer_pkg::phase_t                    phase_out,
    output cartridge_transfer_pkg::error_t                    error_out,
    output logic [cartridge_transfer_pkg::BYTE_CNT_W-1:0]     byte_count_out,
    output logic [cartridge_transfer_pkg::BLOCK_CNT_W-1:0]    block_count_out,
    output logic                                              status_lamp_out,
    output logic                                              buzzer_out
);
    import cartridge_transfer_pkg::*;

    typedef struct packed
    {
        logic                   sampled;
        logic [3:0]             sw1;
        logic [3:0]             sw2;
        phase_t                 phase;
        error_t                 error;
        logic                   manual;
        logic                   to_cart;
        logic                   bank;
        logic                   is_program;
        logic                   second_pass;
        logic [BYTE_CNT_W-1:0]  bytes;
        logic [BLOCK_CNT_W-1:0] blocks;
        logic [BYTE_CNT_W-1:0]  pass_bytes;
        logic [4:0]             prep_cnt;
        logic [BLINK_CNT_W-1:0] blink_cnt;
        logic                   lamp;
        logic                   buzzer;
        logic                   verify_req;
        logic                   dst_is_cart;
        logic                   dst_bank;
        logic                   dst_prog;
    } ctrl_state_t;

    ctrl_state_t st_r;
    ctrl_state_t st_nxt;
    logic        rst_n;
    logic [1:0]  rst_sync_r;
    logic        buf_in_ready;
    logic        buf_in_valid;
    logic [7:0]  buf_out_data;
    logic        buf_out_valid;
    logic        buf_out_ready;
    logic [BLINK_CNT_W-1:0] blink_period;
    logic        mode_err;
    logic        prot_err;
    logic        data_err;
    logic        dest_we;

    // reset release through two flops
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // data path: stall on the destination loses no word
    assign buf_in_valid  = src_valid_in && (st_r.phase == PH_TRANSMIT);
    assign buf_out_ready = dst_ready_in;

    word_skid_buffer u_buf
    (
        .clock_in      (clock_in),
        .reset_n_in    (rst_n),
        .in_data_in    (src_data_in),
        .in_valid_in   (buf_in_valid),
        .in_ready_out  (buf_in_ready),
        .out_data_out  (buf_out_data),
        .out_valid_out (buf_out_valid),
        .out_ready_in  (buf_out_ready)
    );

    // error checks on the held switch image
    always_comb
    begin
        mode_err = mode_err_now(st_r.sw1);
        dest_we  = st_r.to_cart ? st_r.sw2[SW2_CART_WE]
                                : st_r.sw2[SW2_TERM_WE];
        prot_err = !dest_we;
        data_err = 1'b0;
        if (!st_r.to_cart)
        begin
            if (st_r.sw2[SW2_COMBINED])
            begin
                data_err = bank0_is_program_in == bank1_is_program_in;
            end
            else
            begin
                // source kind must match the terminal area it lands in
                data_err = (st_r.bank ? bank1_is_program_in : bank0_is_program_in)
                           != st_r.is_program;
            end
            if (st_r.is_program && !model_match_in)
            begin
                data_err = 1'b1;
            end
        end
    end

    always_comb
    begin
        blink_period = (st_r.phase == PH_PREPARE) ? BLINK_CNT_W'(SLOW_BLINK_CYCLES)
                                                   : BLINK_CNT_W'(FAST_BLINK_CYCLES);
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.verify_req = 1'b0;
        if (!st_r.sampled)
        begin
            // first cycle after reset release only
            st_nxt.sampled = 1'b1;
            st_nxt.sw1 = switch_group1_in;
            st_nxt.sw2 = switch_group2_in;
        end
        else
        begin
            case (st_r.phase)
                PH_IDLE:
                begin
                    st_nxt.manual = st_r.sw1[SW1_MANUAL];
                    if (st_r.sw1[SW1_MANUAL] && !mode_err_now(st_r.sw1))
                    begin
                        if (manual_start_in)
                        begin
                            st_nxt.to_cart = manual_to_cartridge_in;
                            st_nxt.bank    = manual_bank_in;
                            st_nxt.is_program = st_r.sw1[SW1_CONTENT];
                            st_nxt.phase   = PH_PREPARE;
                        end
                    end
                    else
                    begin
                        // automatic modes start with no operator action
                        st_nxt.to_cart = st_r.sw1[SW1_AUTO_BACKUP];
                        st_nxt.is_program = st_r.sw1[SW1_CONTENT];
                        st_nxt.bank = st_r.sw2[SW2_BANK];
                        if (st_r.sw2[SW2_COMBINED])
                        begin
                            st_nxt.is_program = 1'b1;
                            st_nxt.bank = 1'b0;
                        end
                        if (st_r.sw1[SW1_AUTO_LOAD] || st_r.sw1[SW1_AUTO_BACKUP]
                            || mode_err_now(st_r.sw1))
                        begin
                            st_nxt.phase = PH_PREPARE;
                        end
                    end
                    st_nxt.prep_cnt = 5'h0;
                    st_nxt.second_pass = 1'b0;
                    st_nxt.bytes = '0;
                    st_nxt.blocks = '0;
                end
                PH_PREPARE:
                begin
                    st_nxt.prep_cnt = st_r.prep_cnt + 5'h1;
                    if (mode_err)
                    begin
                        st_nxt.error = ERR_MODE;
                        st_nxt.phase = PH_ERROR;
                    end
                    else if (prot_err)
                    begin
                        st_nxt.error = ERR_PROTECT;
                        st_nxt.phase = PH_ERROR;
                    end
                    else if (data_err)
                    begin
                        st_nxt.error = ERR_DATA;
                        st_nxt.phase = PH_ERROR;
                    end
                    else if (st_r.prep_cnt == 5'(PREP_CYCLES - 1))
                    begin
                        st_nxt.phase = PH_TRANSMIT;
                        st_nxt.pass_bytes = '0;
                        st_nxt.dst_is_cart = st_r.to_cart;
                        st_nxt.dst_prog = st_r.is_program;
                        // combined load: program goes from whichever bank holds it
                        if (st_r.sw2[SW2_COMBINED] && !st_r.manual && !st_r.to_cart)
                        begin
                            st_nxt.dst_bank = bank1_is_program_in;
                        end
                        else
                        begin
                            st_nxt.dst_bank = st_r.bank;
                        end
                    end
                end
                PH_TRANSMIT:
                begin
                    if (buf_out_valid && dst_ready_in)
                    begin
                        st_nxt.bytes = st_r.bytes + BYTE_CNT_W'(1);
                        st_nxt.pass_bytes = st_r.pass_bytes + BYTE_CNT_W'(1);
                        if (st_r.pass_bytes[15:0] == 16'hffff)
                        begin
                            st_nxt.blocks = st_r.blocks + BLOCK_CNT_W'(1);
                        end
                        if (st_r.pass_bytes == BYTE_CNT_W'(BANK_BYTES - 1))
                        begin
                            st_nxt.phase = PH_VERIFY;
                            st_nxt.verify_req = 1'b1;
                        end
                    end
                end
                PH_VERIFY:
                begin
                    if (verify_done_in)
                    begin
                        if (!verify_ok_in)
                        begin
                            st_nxt.error = ERR_DATA;
                            st_nxt.phase = PH_ERROR;
                        end
                        else if (st_r.sw2[SW2_COMBINED] && !st_r.manual && !st_r.second_pass)
                        begin
                            // second pass moves the screen data
                            st_nxt.second_pass = 1'b1;
                            st_nxt.phase = PH_TRANSMIT;
                            st_nxt.pass_bytes = '0;
                            st_nxt.dst_prog = 1'b0;
                            st_nxt.dst_bank = st_r.to_cart ? 1'b1 : ~st_r.dst_bank;
                        end
                        else
                        begin
                            st_nxt.phase = PH_FINISHED;
                        end
                    end
                end
                PH_FINISHED:
                begin
                    st_nxt.phase = PH_FINISHED;
                end
                PH_ERROR:
                begin
                    // manual protect error returns on acknowledge
                    if (st_r.manual && st_r.error == ERR_PROTECT && manual_ack_in)
                    begin
                        st_nxt.error = ERR_NONE;
                        st_nxt.phase = PH_IDLE;
                    end
                end
                default:
                begin
                    st_nxt.phase = PH_IDLE;
                end
            endcase
        end

        // lamp and buzzer
        st_nxt.buzzer = (st_nxt.phase == PH_ERROR);
        if (st_nxt.phase != st_r.phase)
        begin
            st_nxt.blink_cnt = '0;
        end
        else if (st_r.blink_cnt >= blink_period - BLINK_CNT_W'(1))
        begin
            st_nxt.blink_cnt = '0;
        end
        else
        begin
            st_nxt.blink_cnt = st_r.blink_cnt + BLINK_CNT_W'(1);
        end
        case (st_nxt.phase)
            PH_PREPARE, PH_TRANSMIT, PH_VERIFY:
            begin
                if (st_r.manual)
                begin
                    st_nxt.lamp = 1'b0;
                end
                else if (st_nxt.phase != st_r.phase)
                begin
                    st_nxt.lamp = 1'b1;
                end
                else if (st_r.blink_cnt >= blink_period - BLINK_CNT_W'(1))
                begin
                    st_nxt.lamp = ~st_r.lamp;
                end
            end
            PH_FINISHED:
            begin
                st_nxt.lamp = !st_r.manual;
            end
            PH_ERROR:
            begin
                if (st_nxt.phase != st_r.phase)
                begin
                    st_nxt.lamp = 1'b1;
                end
                else if (st_r.blink_cnt >= blink_period - BLINK_CNT_W'(1))
                begin
                    st_nxt.lamp = ~st_r.lamp;
                end
            end
            default:
            begin
                st_nxt.lamp = 1'b0;
            end
        endcase
    end

    function automatic logic mode_err_now(input logic [3:0] s);
        mode_err_now = ({1'b0, s[SW1_AUTO_LOAD]} + {1'b0, s[SW1_AUTO_BACKUP]}
                       + {1'b0, s[SW1_MANUAL]}) != 2'h1;
    endfunction

    always_ff @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // idle phase and no error both encode as zero
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign src_ready_out        = buf_in_ready && (st_r.phase == PH_TRANSMIT);
    assign dst_data_out         = buf_out_data;
    assign dst_valid_out        = buf_out_valid;
    assign dst_is_cartridge_out = st_r.dst_is_cart;
    assign dst_bank_out         = st_r.dst_bank;
    assign dst_is_program_out   = st_r.dst_prog;
    assign verify_req_out       = st_r.verify_req;
    assign phase_out            = st_r.phase;
    assign error_out            = st_r.error;
    assign byte_count_out       = st_r.bytes;
    assign block_count_out      = st_r.blocks;
    assign status_lamp_out      = st_r.lamp;
    assign buzzer_out           = st_r.buzzer;
endmodule

/* verilog/cartridge_transfer_pkg.sv */
package cartridge_transfer_pkg;

    // clock and lamp timing
    localparam int unsigned CLOCK_HZ           = 50000000;
    localparam int unsigned SLOW_BLINK_MS      = 1000;
    localparam int unsigned FAST_BLINK_MS      = 500;
    localparam int unsigned SLOW_BLINK_CYCLES  = CLOCK_HZ / 1000 * SLOW_BLINK_MS;
    localparam int unsigned FAST_BLINK_CYCLES  = CLOCK_HZ / 1000 * FAST_BLINK_MS;
    localparam int unsigned BLINK_CNT_W        = 26;

    // bank geometry: 16 blocks, 1024k bytes per bank
    localparam int unsigned BLOCKS_PER_BANK    = 16;
    localparam int unsigned BANK_BYTES         = 1024 * 1024;
    localparam int unsigned BLOCK_BYTES        = BANK_BYTES / BLOCKS_PER_BANK;
    localparam int unsigned BYTE_CNT_W         = 21;
    localparam int unsigned BLOCK_CNT_W        = 5;
    localparam int unsigned PREP_CYCLES        = 16;

    // switch group positions
    localparam int unsigned SW1_AUTO_LOAD      = 0;
    localparam int unsigned SW1_AUTO_BACKUP    = 1;
    localparam int unsigned SW1_MANUAL         = 2;
    localparam int unsigned SW1_CONTENT        = 3;
    localparam int unsigned SW2_TERM_WE        = 0;
    localparam int unsigned SW2_CART_WE        = 1;
    localparam int unsigned SW2_BANK           = 2;
    localparam int unsigned SW2_COMBINED       = 3;

    typedef enum logic [2:0]
    {
        PH_IDLE     = 3'b000,
        PH_PREPARE  = 3'b001,
        PH_TRANSMIT = 3'b010,
        PH_VERIFY   = 3'b011,
        PH_FINISHED = 3'b100,
        PH_ERROR    = 3'b101
    } phase_t;

    typedef enum logic [1:0]
    {
        ERR_NONE    = 2'b00,
        ERR_MODE    = 2'b01,
        ERR_PROTECT = 2'b10,
        ERR_DATA    = 2'b11
    } error_t;

endpackage

/* verilog/word_skid_buffer.sv */
`timescale 1ns/100ps
module word_skid_buffer
(
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic [7:0] in_data_in,
    input  wire logic       in_valid_in,
    output logic            in_ready_out,
    output logic [7:0]      out_data_out,
    output logic            out_valid_out,
    input  wire logic       out_ready_in
);
    typedef struct packed
    {
        logic [1:0][7:0] word;
        logic            rd_idx;
        logic            wr_idx;
        logic [1:0]      count;
    } buf_state_t;

    buf_state_t st_r;
    buf_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (in_valid_in && st_r.count != 2'h2)
        begin
            st_nxt.word[st_r.wr_idx] = in_data_in;
            st_nxt.wr_idx = ~st_r.wr_idx;
        end
        if (out_ready_in && st_r.count != 2'h0)
        begin
            st_nxt.rd_idx = ~st_r.rd_idx;
        end
        st_nxt.count = st_r.count
            + {1'b0, in_valid_in && st_r.count != 2'h2}
            - {1'b0, out_ready_in && st_r.count != 2'h0};
    end

    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign in_ready_out  = st_r.count != 2'h2;
    assign out_valid_out = st_r.count != 2'h0;
    assign out_data_out  = st_r.word[st_r.rd_idx];
endmodule

/* tb/ctc_asserts.sv */
`timescale 1ns/100ps
module ctc_asserts
(
    input wire logic                                       clock_in,
    input wire logic                                       reset_n_in,
    input wire logic                                       src_ready_out,
    input wire logic [7:0]                                 dst_data_out,
    input wire logic                                       dst_valid_out,
    input wire logic                                       dst_ready_in,
    input wire logic                                       dst_is_cartridge_out,
    input wire cartridge_transfer_pkg::phase_t             phase_out,
    input wire cartridge_transfer_pkg::error_t             error_out,
    input wire logic [cartridge_transfer_pkg::BYTE_CNT_W-1:0] byte_count_out,
    input wire logic                                       buzzer_out
);
    import cartridge_transfer_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    sequence prep_start;
        $rose(phase_out == PH_PREPARE);
    endsequence
    sequence prep_run;
        (phase_out == PH_PREPARE)[*8];
    endsequence
    prep_hold_a: assert property (prep_start ##1 phase_out == PH_PREPARE |-> prep_run)
        else $error("prepare phase too short");
    prep_exit_a: assert property (prep_start |-> ##[1:20] phase_out != PH_PREPARE)
        else $error("prepare phase never ends");
    enter_tx_a: assert property ($rose(phase_out == PH_TRANSMIT) |-> $past(phase_out) == PH_PREPARE)
        else $error("transmit not entered from prepare");
    err_buzz_a: assert property ((phase_out == PH_ERROR)[*3] |-> buzzer_out)
        else $error("buzzer silent in error");
    err_hold_a: assert property (phase_out == PH_ERROR && error_out != ERR_PROTECT
        |=> phase_out == PH_ERROR && $stable(error_out))
        else $error("error indication dropped");
    src_gate_a: assert property (src_ready_out |-> phase_out == PH_TRANSMIT)
        else $error("source accepted outside transmit");
    dst_hold_a: assert property (dst_valid_out && !dst_ready_in
        |=> dst_valid_out && $stable(dst_data_out))
        else $error("destination word lost under stall");
    desc_hold_a: assert property (phase_out == PH_TRANSMIT && $past(phase_out) == PH_TRANSMIT
        |-> $stable(dst_is_cartridge_out))
        else $error("direction changed mid transfer");
    count_step_a: assert property ($changed(byte_count_out)
        |-> byte_count_out == $past(byte_count_out) + 1'b1)
        else $error("byte count jumped");
endmodule

/* tb/cartridge_model.sv */
`timescale 1ns/100ps
module cartridge_model
(
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic       run_in,
    output logic [7:0]      src_data_out,
    output logic            src_valid_out,
    input  wire logic       src_ready_in,
    input  wire logic [7:0] dst_data_in,
    input  wire logic       dst_valid_in,
    output logic            dst_ready_out,
    output int              sent_out,
    output int              got_out,
    output logic            bad_out
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [1:0] tick_r;
    // idle data line shows the inverse so nothing stale passes
    assign src_data_out = src_valid_out ? tx_r : ~tx_r;
    assign dst_ready_out = tick_r[1];
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            {tx_r, rx_r, tick_r, src_valid_out, bad_out} <= '0;
            sent_out <= 0;
            got_out <= 0;
        end
        else
        begin
            tick_r <= tick_r + 2'h1;
            if (src_valid_out && src_ready_in)
            begin
                tx_r <= tx_r + 8'h01;
                sent_out <= sent_out + 1;
                src_valid_out <= run_in && tick_r[0];
            end
            else if (!src_valid_out && run_in)
                src_valid_out <= 1'b1;
            if (dst_valid_in && dst_ready_out)
            begin
                bad_out <= bad_out | (dst_data_in !== rx_r);
                rx_r <= rx_r + 8'h01;
                got_out <= got_out + 1;
            end
        end
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import cartridge_transfer_pkg::*;
    logic clock_in = 1'b0, reset_n_in = 1'b0, run = 1'b0, bad;
    logic [3:0] switch_group1_in = 4'h0, switch_group2_in = 4'h0;
    logic manual_start_in = 1'b0, manual_to_cartridge_in = 1'b0, manual_bank_in = 1'b0;
    logic manual_ack_in = 1'b0, bank0_is_program_in = 1'b0, bank1_is_program_in = 1'b0;
    logic model_match_in = 1'b1, verify_done_in = 1'b0, verify_ok_in = 1'b0;
    logic [7:0] src_data_in, dst_data_out;
    logic src_valid_in, src_ready_out, dst_valid_out, dst_ready_in, dst_is_cartridge_out;
    logic dst_bank_out, dst_is_program_out, verify_req_out, status_lamp_out, buzzer_out;
    phase_t phase_out;
    error_t error_out;
    logic [BYTE_CNT_W-1:0] byte_count_out;
    logic [BLOCK_CNT_W-1:0] block_count_out;
    int sent, got, n_fail = 0, compares = 0, cycles = 0;
    cartridge_transfer_control dut (.clock_in, .reset_n_in, .switch_group1_in,
        .switch_group2_in, .manual_start_in, .manual_to_cartridge_in, .manual_bank_in,
        .manual_ack_in, .bank0_is_program_in, .bank1_is_program_in, .model_match_in,
        .src_data_in, .src_valid_in, .src_ready_out, .dst_data_out, .dst_valid_out,
        .dst_ready_in, .dst_is_cartridge_out, .dst_bank_out, .dst_is_program_out,
        .verify_req_out, .verify_done_in, .verify_ok_in, .phase_out, .error_out,
        .byte_count_out, .block_count_out, .status_lamp_out, .buzzer_out);
    cartridge_model cart (.clock_in, .reset_n_in, .run_in(run), .src_data_out(src_data_in),
        .src_valid_out(src_valid_in), .src_ready_in(src_ready_out), .dst_data_in(dst_data_out),
        .dst_valid_in(dst_valid_out), .dst_ready_out(dst_ready_in), .sent_out(sent),
        .got_out(got), .bad_out(bad));
    always #10 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic boot(input logic [3:0] g1, input logic [3:0] g2, input logic [1:0] banks);
        reset_n_in = 1'b0;
        {switch_group1_in, switch_group2_in} = {g1, g2};
        {bank1_is_program_in, bank0_is_program_in} = banks;
        step(10);
        reset_n_in = 1'b1;
    endtask
    task automatic wait_for(input phase_t p);
        for (int i = 0; i < 40 && phase_out !== p; i++)
            step(1);
    endtask
    task automatic manual_go(input logic to_cart, input phase_t p);
        boot(4'h4, 4'h1, 2'h0);
        manual_to_cartridge_in = to_cart;
        step(5);
        manual_start_in = 1'b1;
        step(1);
        manual_start_in = 1'b0;
        wait_for(p);
    endtask
    initial
    begin
        logic [3:0] modes [5] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h7};
        logic [11:0] errs [6] = '{12'h1e2, 12'h2d2, 12'h19f, 12'h193, 12'h913, 12'h117};
        logic [15:0] xfers [4] = '{16'h2e05, 16'h2606, 16'h1500, 16'h9111};
        foreach (modes[i])
        begin
            boot(modes[i], 4'hf, 2'h0);
            wait_for(PH_ERROR);
            chk("mode error", error_out, ERR_MODE);
            switch_group1_in = 4'h1;
            step(5);
            chk("buzzer", buzzer_out, 1'b1);
            chk("error held", phase_out, PH_ERROR);
        end
        foreach (errs[i])
        begin
            boot(errs[i][11:8], errs[i][7:4], errs[i][3:2]);
            wait_for(PH_ERROR);
            chk("setting error", error_out, errs[i][1:0]);
        end
        foreach (xfers[i])
        begin
            boot(xfers[i][15:12], xfers[i][11:8], xfers[i][5:4]);
            step(5);
            chk("prepare", phase_out, PH_PREPARE);
            chk("lamp", status_lamp_out, 1'b1);
            {switch_group1_in, switch_group2_in} = 8'h00;
            wait_for(PH_TRANSMIT);
            chk("target", {dst_is_cartridge_out, dst_is_cartridge_out & dst_bank_out,
                dst_is_program_out}, xfers[i][2:0]);
            run = 1'b1;
            step(300);
            run = 1'b0;
            step(10);
            chk("bytes", byte_count_out, sent);
            chk("drained", got, sent);
            chk("order", bad, 1'b0);
            chk("running", phase_out, PH_TRANSMIT);
        end
        manual_go(1'b0, PH_TRANSMIT);
        chk("manual run", phase_out, PH_TRANSMIT);
        chk("lamp off", status_lamp_out, 1'b0);
        manual_go(1'b1, PH_ERROR);
        chk("manual protect", error_out, ERR_PROTECT);
        manual_ack_in = 1'b1;
        step(1);
        manual_ack_in = 1'b0;
        step(3);
        chk("manual back", phase_out, PH_IDLE);
        complete_run();
    end
endmodule
bind cartridge_transfer_control ctc_asserts chk_i (.clock_in, .reset_n_in, .src_ready_out,
    .dst_data_out, .dst_valid_out, .dst_ready_in, .dst_is_cartridge_out, .phase_out,
    .error_out, .byte_count_out, .buzzer_out);
